// ### pkg/msl_pkg.sv
// constants, register map and frame states of the serial link configuration block
// assumes a single 10 MHz clock shared by every user of this package
package msl_pkg;
    // clock and timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_TIME_US = 1000;
    localparam int MS_CYCLES = (CLK_HZ / 1_000_000) * MS_TIME_US;

    // selectable bit rates, indexed by the rate code
    localparam int RATE_COUNT = 10;
    localparam int RATE_BPS [RATE_COUNT] = '{300, 600, 1200, 2400, 4800, 9600,
                                             19200, 38400, 57600, 115200};

    // parameter addresses
    localparam logic [15:0] ADDR_SAVE_NVM = 16'h0e01;
    localparam logic [15:0] ADDR_BIT_RATE = 16'h0e50;
    localparam logic [15:0] ADDR_CHAR_FMT = 16'h0e51;
    localparam logic [15:0] ADDR_REPLY_DLY = 16'h0e52;
    localparam logic [15:0] ADDR_TIMEOUT = 16'h0e53;
    localparam logic [15:0] ADDR_HALF_ORDER = 16'h0e54;
    localparam logic [15:0] ADDR_VERSION = 16'h0e5a;

    // reset values
    localparam logic RST_SAVE_NVM = 1'h1;
    localparam logic [3:0] RST_BIT_RATE = 4'h9;
    localparam logic [1:0] RST_CHAR_FMT = 2'h3;
    localparam logic [4:0] RST_REPLY_DLY = 5'h00;
    localparam logic [9:0] RST_TIMEOUT = 10'h000;
    localparam logic RST_HALF_ORDER = 1'h1;

    // largest accepted values
    localparam logic [15:0] MAX_BIT_RATE = 16'h0009;
    localparam logic [15:0] MAX_CHAR_FMT = 16'h0003;
    localparam logic [15:0] MAX_REPLY_DLY = 16'h0014;
    localparam logic [15:0] MAX_TIMEOUT = 16'h0258;
    localparam logic [15:0] MAX_FLAG = 16'h0001;

    // character format codes
    localparam logic [1:0] FMT_N2 = 2'h0;
    localparam logic [1:0] FMT_E1 = 2'h1;
    localparam logic [1:0] FMT_O1 = 2'h2;
    localparam logic [1:0] FMT_N1 = 2'h3;

    // order of 16-bit halves
    localparam logic ORDER_HIGH_FIRST = 1'h0;

    // character framing
    localparam logic [3:0] DATA_BITS = 4'h8;

    // version value in hundredths; value is arbitrary
    localparam logic [15:0] LINK_VERSION = 16'h0064;

    // frame states, gray coded along idle-start-data-parity-stop
    typedef enum logic [2:0] {
        FR_IDLE = 3'b000,
        FR_START = 3'b001,
        FR_DATA = 3'b011,
        FR_PARITY = 3'b010,
        FR_STOP = 3'b110
    } msl_frame_t;
endpackage

// ### src/msl_bit_timer.sv
// bit timer: one-cycle tick per bit period at the selected rate
// assumes restart is a one-cycle pulse from logic on the same clock
`timescale 1ns/100ps
module msl_bit_timer #(
    parameter int CLK_HZ = msl_pkg::CLK_HZ
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [3:0] rate_code, // bit-rate code, applied at the next reload
    input wire logic restart, // restart the period
    input wire logic half_first, // first tick after half a period
    output logic tick // one pulse per bit period
);
    logic [15:0] cnt_q;
    logic [15:0] div;

    // divisor rounded to nearest; codes above the table fall back to the fastest rate
    always_comb begin
        div = 16'(((CLK_HZ) + msl_pkg::RATE_BPS[9] / 2) / msl_pkg::RATE_BPS[9]);
        for (int i = 0; i < msl_pkg::RATE_COUNT; i++) begin
            if (rate_code == 4'(i)) begin
                div = 16'((CLK_HZ + msl_pkg::RATE_BPS[i] / 2) / msl_pkg::RATE_BPS[i]);
            end
        end
    end

    // period counter; a rate change takes effect at the next reload
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            tick <= 1'b0;
        end else if (restart) begin
            cnt_q <= half_first ? (div >> 1) : (div - 16'h0001);
            tick <= 1'b0;
        end else if (cnt_q == 16'h0000) begin
            cnt_q <= div - 16'h0001;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// ### src/msl_link_cfg.sv
// serial slave port: parameter registers, character framing, reply delay, timeout
// assumes cmd_done, tx and parameter strobes come from logic on ref_clk
`timescale 1ns/100ps
module msl_link_cfg #(
    parameter int MS_CYCLES = msl_pkg::MS_CYCLES,
    parameter int BAUD_CLK_HZ = msl_pkg::CLK_HZ
) (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [15:0] param_addr, // parameter address
    input wire logic param_wr, // write strobe
    input wire logic param_rd, // read strobe
    input wire logic [15:0] param_wdata, // write data
    output logic [15:0] param_rdata_q, // read data
    output logic param_rvalid_q, // read data valid pulse
    output logic param_werr_q, // refused write pulse
    output logic nvm_save_q, // commit last write to nvm pulse
    input wire logic rx_pin, // serial receive line
    output logic tx_pin_q, // serial transmit line
    output logic [7:0] rx_data_q, // received character
    output logic rx_valid_q, // character received pulse
    output logic rx_err_q, // parity or framing error pulse
    input wire logic [7:0] tx_data, // character to send
    input wire logic tx_valid, // character offered
    output logic tx_ready_q, // transmitter accepts
    input wire logic cmd_done, // full command received pulse
    output logic reply_busy_q, // reply delay running
    output logic timeout_q, // communication timeout flag
    input wire logic [31:0] wide_word, // 32-bit value to split
    input wire logic wide_load, // split strobe
    output logic [15:0] half_first_q, // half sent first
    output logic [15:0] half_second_q // half sent second
);
    logic save_q;
    logic [3:0] rate_q;
    logic [1:0] fmt_q;
    logic [4:0] dly_q;
    logic [9:0] tmo_q;
    logic order_q;
    logic wr_ok;
    logic [15:0] wr_max;
    logic wr_hit;
    logic [15:0] ms_cnt_q;
    logic ms_tick;
    logic [4:0] dly_left_q;
    logic [9:0] gap_q;
    logic armed_q;
    logic rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
    logic rx_fall;
    msl_pkg::msl_frame_t rx_st_q, tx_st_q;
    logic [3:0] rx_cnt_q, tx_cnt_q;
    logic [7:0] rx_sh_q, tx_sh_q;
    logic rx_stop_q, tx_stop_q;
    logic rx_tick, tx_tick;
    logic tx_go;
    logic has_par;
    logic par_odd;

    assign has_par = (fmt_q == msl_pkg::FMT_E1) || (fmt_q == msl_pkg::FMT_O1);
    assign par_odd = (fmt_q == msl_pkg::FMT_O1);

    // address decode and range check; out-of-range values are refused, not clamped
    always_comb begin
        wr_hit = 1'b1;
        wr_max = msl_pkg::MAX_FLAG;
        case (param_addr)
            msl_pkg::ADDR_SAVE_NVM: wr_max = msl_pkg::MAX_FLAG;
            msl_pkg::ADDR_BIT_RATE: wr_max = msl_pkg::MAX_BIT_RATE;
            msl_pkg::ADDR_CHAR_FMT: wr_max = msl_pkg::MAX_CHAR_FMT;
            msl_pkg::ADDR_REPLY_DLY: wr_max = msl_pkg::MAX_REPLY_DLY;
            msl_pkg::ADDR_TIMEOUT: wr_max = msl_pkg::MAX_TIMEOUT;
            msl_pkg::ADDR_HALF_ORDER: wr_max = msl_pkg::MAX_FLAG;
            default: wr_hit = 1'b0;
        endcase
    end
    assign wr_ok = param_wr && wr_hit && (param_wdata <= wr_max);

    // writable settings
    // rate reset value
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            save_q <= msl_pkg::RST_SAVE_NVM;
            rate_q <= msl_pkg::RST_BIT_RATE;
            fmt_q <= msl_pkg::RST_CHAR_FMT;
            dly_q <= msl_pkg::RST_REPLY_DLY;
            tmo_q <= msl_pkg::RST_TIMEOUT;
            order_q <= msl_pkg::RST_HALF_ORDER;
        end else if (wr_ok) begin
            case (param_addr)
                msl_pkg::ADDR_SAVE_NVM: save_q <= param_wdata[0];
                msl_pkg::ADDR_BIT_RATE: rate_q <= param_wdata[3:0];
                msl_pkg::ADDR_CHAR_FMT: fmt_q <= param_wdata[1:0];
                msl_pkg::ADDR_REPLY_DLY: dly_q <= param_wdata[4:0];
                msl_pkg::ADDR_TIMEOUT: tmo_q <= param_wdata[9:0];
                msl_pkg::ADDR_HALF_ORDER: order_q <= param_wdata[0];
                default: save_q <= save_q;
            endcase
        end
    end

    // write side effects: nvm commit request, refusal pulse
    // save per write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nvm_save_q <= 1'b0;
            param_werr_q <= 1'b0;
        end else begin
            nvm_save_q <= wr_ok && save_q;
            param_werr_q <= param_wr && !wr_ok;
        end
    end

    // read port; unmapped addresses read zero
    // version fixed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            param_rdata_q <= 16'h0000;
            param_rvalid_q <= 1'b0;
        end else begin
            param_rvalid_q <= param_rd;
            case (param_addr)
                msl_pkg::ADDR_SAVE_NVM: param_rdata_q <= {15'h0000, save_q};
                msl_pkg::ADDR_BIT_RATE: param_rdata_q <= {12'h000, rate_q};
                msl_pkg::ADDR_CHAR_FMT: param_rdata_q <= {14'h0000, fmt_q};
                msl_pkg::ADDR_REPLY_DLY: param_rdata_q <= {11'h000, dly_q};
                msl_pkg::ADDR_TIMEOUT: param_rdata_q <= {6'h00, tmo_q};
                msl_pkg::ADDR_HALF_ORDER: param_rdata_q <= {15'h0000, order_q};
                msl_pkg::ADDR_VERSION: param_rdata_q <= msl_pkg::LINK_VERSION;
                default: param_rdata_q <= 16'h0000;
            endcase
        end
    end

    // millisecond prescaler, realigned to each command so delays are never short
    always_ff @(posedge ref_clk) begin
        if (rst || cmd_done || ms_tick) begin
            ms_cnt_q <= 16'h0000;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end
    assign ms_tick = (ms_cnt_q == 16'(MS_CYCLES - 1));

    // reply delay after a complete command
    // reply delay count
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dly_left_q <= 5'h00;
            reply_busy_q <= 1'b0;
        end else if (cmd_done) begin
            dly_left_q <= dly_q;
            reply_busy_q <= (dly_q != 5'h00);
        end else if (ms_tick && reply_busy_q) begin
            dly_left_q <= dly_left_q - 5'h01;
            reply_busy_q <= (dly_left_q != 5'h01);
        end
    end

    // gap supervision between requests; a fresh request clears the flag
    // timeout flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gap_q <= 10'h000;
            armed_q <= 1'b0;
            timeout_q <= 1'b0;
        end else if (cmd_done) begin
            gap_q <= 10'h000;
            armed_q <= 1'b1;
            timeout_q <= 1'b0;
        end else begin
            if (ms_tick && gap_q != 10'h3ff) begin
                gap_q <= gap_q + 10'h001;
            end
            if (tmo_q == 10'h000) begin
                timeout_q <= 1'b0;
            end else if (armed_q && gap_q > tmo_q) begin
                timeout_q <= 1'b1;
            end
        end
    end

    // 32-bit split into halves
    // half order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            half_first_q <= 16'h0000;
            half_second_q <= 16'h0000;
        end else if (wide_load) begin
            half_first_q <= (order_q == msl_pkg::ORDER_HIGH_FIRST) ?
                wide_word[31:16] : wide_word[15:0];
            half_second_q <= (order_q == msl_pkg::ORDER_HIGH_FIRST) ?
                wide_word[15:0] : wide_word[31:16];
        end
    end

    // receive line synchroniser; level moves only when second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            rx_s3_q <= 1'b1;
            rx_lvl_q <= 1'b1;
        end else begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_s3_q <= rx_s2_q;
            if (rx_s2_q == rx_s3_q) begin
                rx_lvl_q <= rx_s3_q;
            end
        end
    end
    assign rx_fall = rx_lvl_q && !rx_s2_q && !rx_s3_q && (rx_st_q == msl_pkg::FR_IDLE);

    msl_bit_timer #(.CLK_HZ(BAUD_CLK_HZ)) u_rx_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .rate_code(rate_q),
        .restart(rx_fall),
        .half_first(1'b1),
        .tick(rx_tick)
    );

    // receive framing, sampled mid-bit
    // receive format
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_st_q <= msl_pkg::FR_IDLE;
            rx_cnt_q <= 4'h0;
            rx_sh_q <= 8'h00;
            rx_stop_q <= 1'b0;
            rx_data_q <= 8'h00;
            rx_valid_q <= 1'b0;
            rx_err_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            rx_err_q <= 1'b0;
            case (rx_st_q)
                msl_pkg::FR_IDLE: begin
                    if (rx_fall) begin
                        rx_st_q <= msl_pkg::FR_START;
                    end
                end
                msl_pkg::FR_START: begin
                    if (rx_tick) begin
                        rx_st_q <= rx_lvl_q ? msl_pkg::FR_IDLE : msl_pkg::FR_DATA;
                        rx_cnt_q <= 4'h0;
                    end
                end
                msl_pkg::FR_DATA: begin
                    if (rx_tick) begin
                        rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]};
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == msl_pkg::DATA_BITS - 4'h1) begin
                            rx_st_q <= has_par ? msl_pkg::FR_PARITY : msl_pkg::FR_STOP;
                            rx_stop_q <= (fmt_q == msl_pkg::FMT_N2);
                        end
                    end
                end
                msl_pkg::FR_PARITY: begin
                    if (rx_tick) begin
                        rx_err_q <= (^rx_sh_q ^ par_odd) != rx_lvl_q;
                        rx_st_q <= msl_pkg::FR_STOP;
                    end
                end
                msl_pkg::FR_STOP: begin
                    if (rx_tick) begin
                        if (!rx_lvl_q) begin
                            rx_err_q <= 1'b1;
                            rx_st_q <= msl_pkg::FR_IDLE;
                        end else if (rx_stop_q) begin
                            rx_stop_q <= 1'b0;
                        end else begin
                            rx_data_q <= rx_sh_q;
                            rx_valid_q <= 1'b1;
                            rx_st_q <= msl_pkg::FR_IDLE;
                        end
                    end
                end
                default: rx_st_q <= msl_pkg::FR_IDLE;
            endcase
        end
    end

    // a new command holds the transmitter off in the same cycle
    // transmit held off
    assign tx_go = tx_valid && tx_ready_q && !cmd_done;

    msl_bit_timer #(.CLK_HZ(BAUD_CLK_HZ)) u_tx_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .rate_code(rate_q),
        .restart(tx_go),
        .half_first(1'b0),
        .tick(tx_tick)
    );

    // transmit framing; the ready flag lags the state by one cycle, hence the extra gates
    // transmit format
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tx_st_q <= msl_pkg::FR_IDLE;
            tx_cnt_q <= 4'h0;
            tx_sh_q <= 8'h00;
            tx_stop_q <= 1'b0;
            tx_pin_q <= 1'b1;
            tx_ready_q <= 1'b0;
        end else begin
            tx_ready_q <= (tx_st_q == msl_pkg::FR_IDLE) && !tx_go && !reply_busy_q
                && !cmd_done;
            case (tx_st_q)
                msl_pkg::FR_IDLE: begin
                    if (tx_go) begin
                        tx_sh_q <= tx_data;
                        tx_pin_q <= 1'b0;
                        tx_st_q <= msl_pkg::FR_START;
                    end
                end
                msl_pkg::FR_START: begin
                    if (tx_tick) begin
                        tx_pin_q <= tx_sh_q[0];
                        tx_cnt_q <= 4'h1;
                        tx_st_q <= msl_pkg::FR_DATA;
                    end
                end
                msl_pkg::FR_DATA: begin
                    if (tx_tick) begin
                        if (tx_cnt_q == msl_pkg::DATA_BITS) begin
                            tx_pin_q <= has_par ? (^tx_sh_q ^ par_odd) : 1'b1;
                            tx_st_q <= has_par ? msl_pkg::FR_PARITY : msl_pkg::FR_STOP;
                            tx_stop_q <= (fmt_q == msl_pkg::FMT_N2);
                        end else begin
                            tx_pin_q <= tx_sh_q[tx_cnt_q[2:0]];
                            tx_cnt_q <= tx_cnt_q + 4'h1;
                        end
                    end
                end
                msl_pkg::FR_PARITY: begin
                    if (tx_tick) begin
                        tx_pin_q <= 1'b1;
                        tx_st_q <= msl_pkg::FR_STOP;
                    end
                end
                msl_pkg::FR_STOP: begin
                    if (tx_tick) begin
                        if (tx_stop_q) begin
                            tx_stop_q <= 1'b0;
                        end else begin
                            tx_st_q <= msl_pkg::FR_IDLE;
                        end
                    end
                end
                default: tx_st_q <= msl_pkg::FR_IDLE;
            endcase
        end
    end

    // checks
    sequence s_cmd_with_delay;
        cmd_done && dly_q != 5'h00;
    endsequence
    a_rate_reset: assert property (@(posedge ref_clk) rst |=> rate_q == 4'h9)
        else $error("rate code not 9 after reset");
    a_rate_range: assert property (@(posedge ref_clk) disable iff (rst) rate_q <= 4'h9)
        else $error("rate code out of range");
    a_fmt_reset: assert property (@(posedge ref_clk) rst |=> fmt_q == 2'h3)
        else $error("format not 3 after reset");
    a_tmo_range: assert property (@(posedge ref_clk) disable iff (rst) tmo_q <= 10'h258)
        else $error("timeout setting above 600");
    a_delay_busy: assert property (@(posedge ref_clk) disable iff (rst)
        s_cmd_with_delay ##1 !cmd_done |-> reply_busy_q && !tx_go)
        else $error("reply not held after command");
    a_busy_no_tx: assert property (@(posedge ref_clk) disable iff (rst)
        reply_busy_q |-> !tx_go)
        else $error("transmit started during reply delay");
    a_nvm_commit: assert property (@(posedge ref_clk) disable iff (rst)
        param_wr |=> nvm_save_q == (!param_werr_q && $past(save_q)))
        else $error("nvm commit does not follow save setting");
    a_version_ro: assert property (@(posedge ref_clk) disable iff (rst)
        param_rd && param_addr == msl_pkg::ADDR_VERSION |=>
        param_rvalid_q && param_rdata_q == msl_pkg::LINK_VERSION)
        else $error("version read changed");
    a_tmo_off: assert property (@(posedge ref_clk) disable iff (rst)
        tmo_q == 10'h000 |=> !timeout_q)
        else $error("timeout flagged while disabled");
    a_half_order: assert property (@(posedge ref_clk) disable iff (rst)
        wide_load |=> half_first_q == ($past(order_q) ? $past(wide_word[15:0])
        : $past(wide_word[31:16])))
        else $error("wrong half sent first");
endmodule

// ### tb/msl_host_model.sv
// host master model: frames characters onto the slave receive line, decodes its transmit line
// assumes the bit period in ref_clk cycles is handed to each call
`timescale 1ns/100ps
module msl_host_model (
    input wire logic ref_clk, // system clock
    output logic rx_line, // to slave receive pin, idles high
    input wire logic tx_line // from slave transmit pin
);
    initial rx_line = 1'h1;
    // one bit, launched at a falling edge
    task automatic put(input logic b, input int div);
        @(negedge ref_clk);
        rx_line = b;
        repeat (div - 1) @(negedge ref_clk);
    endtask
    // same rate and format as the slave; bad flips parity on purpose
    task automatic send(input logic [7:0] d, input logic [1:0] f, input int div, input logic bad);
        put(1'h0, div);
        for (int i = 0; i < 8; i++) put(d[i], div);
        if (f == 2'h1 || f == 2'h2) put(^d ^ (f == 2'h2) ^ bad, div);
        put(1'h1, div);
        if (f == 2'h0) put(1'h1, div);
    endtask
    // sampled mid-bit so line updates at bit borders never race the read
    task automatic recv(input logic [1:0] f, input int div, output logic [7:0] d, output logic ok);
        int w;
        w = 0;
        while (tx_line !== 1'h0 && w < 5000) begin
            @(posedge ref_clk);
            w++;
        end
        repeat (div / 2) @(posedge ref_clk);
        ok = tx_line === 1'h0 && w < 5000;
        for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge ref_clk);
            d[i] = tx_line;
        end
        if (f == 2'h1 || f == 2'h2) begin
            repeat (div) @(posedge ref_clk);
            ok &= tx_line === (^d ^ (f == 2'h2));
        end
        repeat (div) @(posedge ref_clk);
        ok &= tx_line === 1'h1;
    endtask
endmodule

// ### tb/tb_msl_link_cfg.sv
// bench for the serial link block: registers, framing, reply delay, timeout, halves
// assumes the host model sits on the serial pins; baud clock reduced to ten cycles a bit at 115200
`timescale 1ns/100ps
module tb_msl_link_cfg;
    localparam int BAUD = 1152000;
    localparam int DIV = 10;
    logic ref_clk = 1'h0, rst = 1'h1, param_wr = 1'h0, param_rd = 1'h0, tx_valid = 1'h0;
    logic cmd_done = 1'h0, wide_load = 1'h0;
    logic [15:0] param_addr = 16'h0000, param_wdata = 16'h0000;
    logic [7:0] tx_data = 8'h00;
    logic [31:0] wide_word = 32'h0000_0000;
    logic param_rvalid_q, param_werr_q, nvm_save_q, rx_pin, tx_pin_q, rx_valid_q, rx_err_q;
    logic tx_ready_q, reply_busy_q, timeout_q, g_err, g_nvm, g_ok, g_rv;
    logic [15:0] param_rdata_q, half_first_q, half_second_q, g_rd;
    logic [7:0] rx_data_q, g_ch;
    int errors = 0, tests_run = 0, n_rx = 0, n_err = 0;

    msl_link_cfg #(.MS_CYCLES(10), .BAUD_CLK_HZ(BAUD)) i_msl_link_cfg (.ref_clk, .rst,
        .param_addr, .param_wr, .param_rd, .param_wdata, .param_rdata_q, .param_rvalid_q,
        .param_werr_q, .nvm_save_q, .rx_pin, .tx_pin_q, .rx_data_q, .rx_valid_q, .rx_err_q,
        .tx_data, .tx_valid, .tx_ready_q, .cmd_done, .reply_busy_q, .timeout_q, .wide_word,
        .wide_load, .half_first_q, .half_second_q);
    msl_host_model i_msl_host_model (.ref_clk, .rx_line(rx_pin), .tx_line(tx_pin_q));

    // clock, and receive pulse counts taken away from the launching edge
    always #50 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        n_rx += int'(rx_valid_q === 1'h1);
        n_err += int'(rx_err_q === 1'h1);
    end

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one access; a leading edge keeps strobes apart between calls
    task automatic acc(input logic [15:0] a, input logic w, input logic [15:0] d);
        @(negedge ref_clk);
        param_addr = a;
        param_wdata = d;
        param_wr = w;
        param_rd = !w;
        @(negedge ref_clk);
        param_wr = 1'h0;
        param_rd = 1'h0;
        {g_err, g_nvm, g_rv, g_rd} = {param_werr_q, nvm_save_q, param_rvalid_q, param_rdata_q};
    endtask
    task automatic cmd();
        cmd_done = 1'h1;
        @(negedge ref_clk);
        cmd_done = 1'h0;
    endtask
    task automatic t_reset();
        logic [15:0] val [7];
        val = '{16'h0001, 16'h0009, 16'h0003, 16'h0000, 16'h0000, 16'h0001, msl_pkg::LINK_VERSION};
        foreach (val[i]) begin
            acc(i == 0 ? 16'h0e01 : (i == 6 ? 16'h0e5a : 16'h0e4f + 16'(i)), 1'h0, 16'h0000);
            check("reset", val[i], g_rd);
            check("rvalid", 1'h1, g_rv);
        end
        $display("test reset done");
    endtask
    // boundary and refused writes; the save bit is tracked as it was before each write
    task automatic t_write();
        logic [15:0] ad [13], dt [13], rb [13];
        logic sv;
        ad = '{16'h0e50, 16'h0e50, 16'h0e50, 16'h0e51, 16'h0e52, 16'h0e52, 16'h0e53, 16'h0e53,
            16'h0e54, 16'h0e5a, 16'h0e01, 16'h0e50, 16'h0e55};
        dt = '{16'h000a, 16'h0000, 16'h0009, 16'h0004, 16'h0015, 16'h0014, 16'h0259, 16'h0258,
            16'h0002, 16'h0000, 16'h0000, 16'h0009, 16'h0001};
        rb = '{16'h0009, 16'h0000, 16'h0009, 16'h0003, 16'h0000, 16'h0014, 16'h0000, 16'h0258,
            16'h0001, msl_pkg::LINK_VERSION, 16'h0000, 16'h0009, 16'h0000};
        sv = 1'h1;
        for (int i = 0; i < 13; i++) begin
            acc(ad[i], 1'h1, dt[i]);
            check("refused", 13'h1359 >> i & 1, g_err);
            check("nvm", !(13'h1359 >> i & 1) && sv, g_nvm);
            if (i == 10) sv = 1'h0;
            acc(ad[i], 1'h0, 16'h0000);
            if (i < 12) check("readback", rb[i], g_rd);
        end
        acc(16'h0e01, 1'h1, 16'h0001);
        $display("test write done");
    endtask
    task automatic rx1(input logic [7:0] d, input logic [1:0] f, input int div, input logic bad);
        int v, e;
        {v, e} = {n_rx, n_err};
        i_msl_host_model.send(d, f, div, bad);
        repeat (3) @(negedge ref_clk);
        check("rx data", d, rx_data_q);
        check("rx err", bad, n_err - e);
        if (!bad) check("rx valid", 1, n_rx - v);
    endtask
    // rate codes change between characters and apply from the next start bit
    task automatic t_rx();
        for (int r = 0; r < 10; r++) begin
            acc(16'h0e50, 1'h1, 16'(r));
            rx1(8'h3c + 8'(r), 2'h3, BAUD / msl_pkg::RATE_BPS[r], 1'h0);
        end
        for (int f = 0; f < 4; f++) begin
            acc(16'h0e51, 1'h1, 16'(f));
            rx1(8'hc1 + 8'(f), 2'(f), DIV, f == 2);
        end
        $display("test rx done");
    endtask
    task automatic t_tx();
        int w;
        for (int f = 0; f < 4; f++) begin
            repeat (2 * DIV) @(negedge ref_clk);
            acc(16'h0e51, 1'h1, 16'(f));
            w = 0;
            fork
                i_msl_host_model.recv(2'(f), DIV, g_ch, g_ok);
                begin
                    while (tx_ready_q !== 1'h1 && w < 500) begin
                        @(negedge ref_clk);
                        w++;
                    end
                    {tx_data, tx_valid} = {8'h96 ^ 8'(f), 1'h1};
                    @(negedge ref_clk);
                    tx_valid = 1'h0;
                end
            join
            check("tx char", 8'h96 ^ 8'(f), g_ch);
            check("tx frame", 1'h1, g_ok);
        end
        $display("test tx done");
    endtask
    task automatic t_misc();
        int n;
        wide_word = 32'h1234_abcd;
        for (int o = 1; o >= 0; o--) begin
            acc(16'h0e54, 1'h1, 16'(o));
            wide_load = 1'h1;
            @(negedge ref_clk);
            wide_load = 1'h0;
            check("halves", o ? 32'habcd_1234 : 32'h1234_abcd, {half_first_q, half_second_q});
        end
        acc(16'h0e52, 1'h1, 16'h0002);
        cmd();
        check("ready held", 1'h0, tx_ready_q);
        n = 0;
        while (reply_busy_q === 1'h1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        check("delay", 20, n);
        acc(16'h0e52, 1'h1, 16'h0000);
        acc(16'h0e53, 1'h1, 16'h0003);
        cmd();
        check("no delay", 1'h0, reply_busy_q);
        repeat (30) @(negedge ref_clk);
        check("timeout early", 1'h0, timeout_q);
        repeat (20) @(negedge ref_clk);
        check("timeout set", 1'h1, timeout_q);
        cmd();
        check("timeout clear", 1'h0, timeout_q);
        acc(16'h0e53, 1'h1, 16'h0000);
        repeat (60) @(negedge ref_clk);
        check("timeout off", 1'h0, timeout_q);
        $display("test delay timeout done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge ref_clk);
        rst = 1'h0;
        t_reset();
        t_write();
        t_rx();
        t_tx();
        t_misc();
        finish_test();
    end
    // watchdog beyond the roughly 78000 cycles the tests take, most of them at the slow rates
    initial begin
        #9000000;
        errors++;
        finish_test();
    end
endmodule
